/* File: hdl/drive_stop_mode_sequencer.v */
// stop-mode sequencer and operation frequency clamp for a motor inverter
//
// Contract
// - the stop mode setting spans 0 to 4, with 0 deceleration, 2 free run, 4 power braking, default 0.
// - deceleration stop ramps the output down to 0 Hz and then stops driving.
// - DC-braking stop decelerates until the entry frequency is reached, then goes to DC injection.
// - before injection the output is held blocked for the blanking duration.
// - DC is applied for the hold duration.
// - the injection amount is a percentage of rated current, 0 to 200, default 50.
// - a dwell frequency below the entry frequency skips the dwell and brakes instead.
// - free-run stop cuts the output as soon as the run command drops.
// - power braking slows or reverses the ramp while bus overvoltage is seen.
// - stall prevention and power braking act only while decelerating, power braking taking precedence.
// - a request below the floor frequency counts as 0 Hz and the floor bounds speed settings.
// - requests above the ceiling frequency are clamped to it, the nominal frequency excepted.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "stop_seq_regs.vh"
module drive_stop_mode_sequencer #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        MCLK_I,
  input  wire        NRST_I,
  input  wire        CE_I,
  input  wire        RUN_CMD_I,
  input  wire        BUS_OVERVOLT_I,
  input  wire        DWELL_ENABLE_I,
  input  wire [15:0] DWELL_FREQ_I,
  input  wire [15:0] REQ_FREQ_I,
  input  wire [15:0] RAMP_STEP_I,
  input  wire [15:0] NOMINAL_FREQ_I,
  input  wire [7:0]  ADDR_I,
  input  wire [15:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [15:0] RDATA_O,
  output reg  [15:0] OUT_FREQ_O,
  output reg         OUT_ENABLE_O,
  output reg         DC_INJECT_O,
  output reg  [7:0]  INJ_LEVEL_O,
  output reg         DWELL_ACTIVE_O,
  output reg         STALL_ACTIVE_O,
  output reg         POWER_BRAKE_ACTIVE_O,
  output reg         STOP_DONE_O,
  output wire [15:0] CLAMPED_FREQ_O,
  output wire [15:0] NOMINAL_FREQ_O
);
  // -----------------------------------------
  // register offsets
  // -----------------------------------------
  localparam [7:0] A_MODE    = 8'h00;
  localparam [7:0] A_BLANK   = 8'h01;
  localparam [7:0] A_HOLD    = 8'h02;
  localparam [7:0] A_INJPCT  = 8'h03;
  localparam [7:0] A_ENTRY   = 8'h04;
  localparam [7:0] A_FLOOR   = 8'h05;
  localparam [7:0] A_CEIL    = 8'h06;
  localparam [7:0] A_STALL   = 8'h07;
  localparam [7:0] A_STATUS  = 8'h08;
  localparam [7:0] A_OUTFREQ = 8'h09;
  // -----------------------------------------
  // sequencer states
  // -----------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RUN   = 3'h1;
  localparam [2:0] S_DECEL = 3'h2;
  localparam [2:0] S_DWELL = 3'h3;
  localparam [2:0] S_BLANK = 3'h4;
  localparam [2:0] S_INJ   = 3'h5;
  localparam [2:0] S_OFF   = 3'h6;

  reg  [2:0]  stop_mode;
  reg  [15:0] output_blank_duration;
  reg  [15:0] injection_hold_duration;
  reg  [7:0]  injection_current_percent;
  reg  [15:0] injection_entry_frequency;
  reg  [15:0] floor_frequency_setting;
  reg  [15:0] ceiling_frequency_setting;
  reg  [7:0]  stall_guard_options;
  reg  [2:0]  latched_mode;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [15:0] next_freq;
  reg         tmr_load;
  reg  [15:0] tmr_count;
  wire        tmr_done;
  reg         run_meta;
  reg         run_sync;
  reg         ov_meta;
  reg         ov_sync;
  reg  [15:0] target;
  wire        decel_phase;
  wire        stall_req;
  reg  [15:0] ramp_down;
  reg  [15:0] ramp_up;

  // -----------------------------------------
  // pin synchronisers
  // -----------------------------------------
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      ov_meta  <= 1'b0;
      ov_sync  <= 1'b0;
    end else if (CE_I) begin
      run_meta <= RUN_CMD_I;
      run_sync <= run_meta;
      ov_meta  <= BUS_OVERVOLT_I;
      ov_sync  <= ov_meta;
    end
  end

  // -----------------------------------------
  // frequency clamp
  // -----------------------------------------
  // below floor reads as zero, above ceiling saturates
  assign CLAMPED_FREQ_O = (REQ_FREQ_I < floor_frequency_setting) ? 16'h0000 :
                          (REQ_FREQ_I > ceiling_frequency_setting) ? ceiling_frequency_setting :
                          REQ_FREQ_I;
  // nominal frequency passes the ceiling unclamped
  assign NOMINAL_FREQ_O = NOMINAL_FREQ_I;

  // -----------------------------------------
  // settings writes, out-of-range values are refused
  // -----------------------------------------
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      stop_mode                 <= `MODE_RESET;
      output_blank_duration     <= `BLANK_TIME_RESET;
      injection_hold_duration   <= `HOLD_TIME_RESET;
      injection_current_percent <= `INJ_PCT_RESET;
      injection_entry_frequency <= `ENTRY_FREQ_RESET;
      floor_frequency_setting   <= `FLOOR_FREQ_RESET;
      ceiling_frequency_setting <= `CEIL_FREQ_RESET;
      stall_guard_options       <= 8'h00;
    end else if (CE_I && WR_I) begin
      case (ADDR_I)
        A_MODE: if (WDATA_I <= 16'h0004) stop_mode <= WDATA_I[2:0];
        A_BLANK: if (WDATA_I <= `TIME_MAX) output_blank_duration <= WDATA_I;
        A_HOLD: if (WDATA_I <= `TIME_MAX) injection_hold_duration <= WDATA_I;
        A_INJPCT: if (WDATA_I <= {8'h00, `INJ_PCT_MAX}) injection_current_percent <= WDATA_I[7:0];
        A_ENTRY: if (WDATA_I <= `ENTRY_FREQ_MAX) injection_entry_frequency <= WDATA_I;
        A_FLOOR: if (WDATA_I >= `FLOOR_FREQ_MIN && WDATA_I <= `FLOOR_FREQ_MAX) floor_frequency_setting <= WDATA_I;
        A_CEIL: if (WDATA_I >= `CEIL_FREQ_MIN && WDATA_I <= `CEIL_FREQ_MAX) ceiling_frequency_setting <= WDATA_I;
        A_STALL: stall_guard_options <= WDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // -----------------------------------------
  // read port, data one cycle after the strobe
  // -----------------------------------------
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      RDATA_O <= 16'h0000;
    end else if (CE_I) begin
      if (RD_I) begin
        case (ADDR_I)
          A_MODE:    RDATA_O <= {13'h0000, stop_mode};
          A_BLANK:   RDATA_O <= output_blank_duration;
          A_HOLD:    RDATA_O <= injection_hold_duration;
          A_INJPCT:  RDATA_O <= {8'h00, injection_current_percent};
          A_ENTRY:   RDATA_O <= injection_entry_frequency;
          A_FLOOR:   RDATA_O <= floor_frequency_setting;
          A_CEIL:    RDATA_O <= ceiling_frequency_setting;
          A_STALL:   RDATA_O <= {8'h00, stall_guard_options};
          A_STATUS:  RDATA_O <= {10'h000, latched_mode, state};
          A_OUTFREQ: RDATA_O <= OUT_FREQ_O;
          default:   RDATA_O <= 16'h0000; // unmapped reads zero
        endcase
      end else begin
        RDATA_O <= 16'h0000;
      end
    end
  end

  // -----------------------------------------
  // shared timer for blanking and hold phases
  // -----------------------------------------
  tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_i   (MCLK_I),
    .nrst_i  (NRST_I),
    .ce_i    (CE_I),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  // -----------------------------------------
  // ramp helpers
  // -----------------------------------------
  // power braking and stall guard only matter while slowing down
  assign decel_phase = (state == S_DECEL) || (state == S_DWELL);
  assign stall_req   = stall_guard_options[`STALL_DECEL_BIT] && ov_sync && decel_phase &&
                       (latched_mode != `MODE_POWERBRAKE);
  always @* begin
    ramp_down = (OUT_FREQ_O > RAMP_STEP_I) ? OUT_FREQ_O - RAMP_STEP_I : 16'h0000;
    ramp_up   = (OUT_FREQ_O > 16'hFFFF - RAMP_STEP_I) ? 16'hFFFF : OUT_FREQ_O + RAMP_STEP_I;
    target    = CLAMPED_FREQ_O;
  end

  // -----------------------------------------
  // next-state logic
  // -----------------------------------------
  always @* begin
    next_state = state;
    next_freq  = OUT_FREQ_O;
    tmr_load   = 1'b0;
    tmr_count  = 16'h0000;
    case (state)
      S_IDLE, S_OFF: begin
        next_freq = 16'h0000;
        if (run_sync) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (!run_sync) begin
          // mode is latched here so later writes wait for the next stop
          if (stop_mode == `MODE_FREERUN) begin
            next_state = S_OFF;
            next_freq  = 16'h0000;
          end else begin
            next_state = S_DECEL;
          end
        end else if (OUT_FREQ_O < target) begin
          next_freq = (ramp_up > target) ? target : ramp_up;
        end else begin
          next_freq = (ramp_down < target) ? target : ramp_down;
        end
      end
      S_DECEL: begin
        if (latched_mode == `MODE_POWERBRAKE && ov_sync) begin
          // regenerated energy: back off by re-accelerating one step
          next_freq = ramp_up;
        end else if (stall_req) begin
          next_freq = OUT_FREQ_O; // hold the ramp while stall guard acts
        end else if (latched_mode == `MODE_DCBRAKE && OUT_FREQ_O <= injection_entry_frequency) begin
          next_state = S_BLANK;
          tmr_load   = 1'b1;
          tmr_count  = output_blank_duration;
        end else if (DWELL_ENABLE_I && OUT_FREQ_O <= DWELL_FREQ_I && OUT_FREQ_O > 16'h0000 &&
                     !(latched_mode == `MODE_DCBRAKE && DWELL_FREQ_I < injection_entry_frequency)) begin
          next_state = S_DWELL;
        end else if (OUT_FREQ_O == 16'h0000) begin
          next_state = S_OFF;
        end else begin
          next_freq = ramp_down;
        end
      end
      S_DWELL: begin
        // dwell holds frequency until the dwell request drops
        if (!DWELL_ENABLE_I) begin
          next_state = S_DECEL;
          next_freq  = ramp_down;
        end
      end
      S_BLANK: begin
        next_freq = 16'h0000;
        if (tmr_done && !tmr_load) begin
          next_state = S_INJ;
          tmr_load   = 1'b1;
          tmr_count  = injection_hold_duration;
        end
      end
      S_INJ: begin
        next_freq = 16'h0000;
        if (tmr_done) begin
          next_state = S_OFF;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_freq  = 16'h0000;
      end
    endcase
  end

  // -----------------------------------------
  // state and output registers
  // -----------------------------------------
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      state                <= S_IDLE;
      latched_mode         <= `MODE_RESET;
      OUT_FREQ_O           <= 16'h0000;
      OUT_ENABLE_O         <= 1'b0;
      DC_INJECT_O          <= 1'b0;
      INJ_LEVEL_O          <= 8'h00;
      DWELL_ACTIVE_O       <= 1'b0;
      STALL_ACTIVE_O       <= 1'b0;
      POWER_BRAKE_ACTIVE_O <= 1'b0;
      STOP_DONE_O          <= 1'b0;
    end else if (CE_I) begin
      state      <= next_state;
      OUT_FREQ_O <= next_freq;
      if (state == S_RUN && !run_sync) begin
        latched_mode <= stop_mode;
      end
      OUT_ENABLE_O         <= (next_state == S_RUN) || (next_state == S_DECEL) || (next_state == S_DWELL) ||
                              (next_state == S_INJ);
      DC_INJECT_O          <= (next_state == S_INJ);
      INJ_LEVEL_O          <= (next_state == S_INJ) ? injection_current_percent : 8'h00;
      DWELL_ACTIVE_O       <= (next_state == S_DWELL);
      STALL_ACTIVE_O       <= stall_req;
      POWER_BRAKE_ACTIVE_O <= (state == S_DECEL) && (latched_mode == `MODE_POWERBRAKE) && ov_sync;
      STOP_DONE_O          <= (next_state == S_OFF);
    end
  end
endmodule // drive_stop_mode_sequencer

/* File: hdl/stop_seq_regs.vh */
// constants for the stop-mode sequencer: modes, setting defaults and timing counts
`ifndef STOP_SEQ_REGS_VH
`define STOP_SEQ_REGS_VH
// stop mode selector codes
`define MODE_DECEL        3'h0
`define MODE_DCBRAKE      3'h1
`define MODE_FREERUN      3'h2
`define MODE_POWERBRAKE   3'h4
`define MODE_RESET        3'h0
// frequency settings in 0.01 Hz units
`define FLOOR_FREQ_RESET  16'h0032
`define FLOOR_FREQ_MIN    16'h0001
`define FLOOR_FREQ_MAX    16'h03E8
`define CEIL_FREQ_RESET   16'h1770
`define CEIL_FREQ_MIN     16'h0FA0
`define CEIL_FREQ_MAX     16'h9C40
`define ENTRY_FREQ_RESET  16'h01F4
`define ENTRY_FREQ_MAX    16'h1770
// durations in 0.01 s units
`define BLANK_TIME_RESET  16'h000A
`define HOLD_TIME_RESET   16'h0064
`define TIME_MAX          16'h1770
// injection level in percent
`define INJ_PCT_RESET     8'h32
`define INJ_PCT_MAX       8'hC8
// stall guard option bit for stall prevention during deceleration
`define STALL_DECEL_BIT   3
// clock rate and tick derivation: one tick is 10 ms
`define CLK_HZ            20000000
`define TICK_MS           10
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`endif

/* File: hdl/tick_timer.v */
// down-counter of 10 ms ticks with a done flag
`timescale 1ns/100ps
module tick_timer #(
  parameter TICK_CYCLES = 200000
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        ce_i,
  input  wire        load_i,
  input  wire [15:0] count_i,
  output reg         done_o
);
  reg [17:0] prescale;
  reg [15:0] remain;
  // -----------------------------------------
  // prescaler and tick countdown
  // -----------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      prescale <= 18'h00000;
      remain   <= 16'h0000;
      done_o   <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        prescale <= 18'h00000;
        remain   <= count_i;
        done_o   <= (count_i == 16'h0000); // zero duration ends at once
      end else if (!done_o) begin
        if (prescale == TICK_CYCLES[17:0] - 18'h00001) begin
          prescale <= 18'h00000;
          if (remain <= 16'h0001) begin
            remain <= 16'h0000;
            done_o <= 1'b1;
          end else begin
            remain <= remain - 16'h0001;
          end
        end else begin
          prescale <= prescale + 18'h00001;
        end
      end
    end
  end
endmodule // tick_timer

/* File: test/drive_stop_mode_sequencer_properties.sv */
// port-level checks for the stop-mode sequencer
`timescale 1ns/100ps
module stop_seq_checker (
  input wire        MCLK_I,
  input wire        NRST_I,
  input wire        RD_I,
  input wire [15:0] RDATA_O,
  input wire [15:0] REQ_FREQ_I,
  input wire [15:0] CLAMPED_FREQ_O,
  input wire [15:0] NOMINAL_FREQ_I,
  input wire [15:0] NOMINAL_FREQ_O,
  input wire [15:0] OUT_FREQ_O,
  input wire        OUT_ENABLE_O,
  input wire        DC_INJECT_O,
  input wire [7:0]  INJ_LEVEL_O,
  input wire        DWELL_ACTIVE_O,
  input wire        STALL_ACTIVE_O,
  input wire        POWER_BRAKE_ACTIVE_O,
  input wire        STOP_DONE_O
);
  // ----------------------------------------
  // assertions, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  AST_RDATA_SLOT: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data seen outside its slot");
  AST_CLAMP_FORM: assert property (CLAMPED_FREQ_O < REQ_FREQ_I |-> CLAMPED_FREQ_O == 16'h0000 || CLAMPED_FREQ_O >= 16'h0FA0)
    else $error("clamp lowered request to an illegal value");
  AST_CLAMP_CEIL: assert property (CLAMPED_FREQ_O <= 16'h9C40 && CLAMPED_FREQ_O <= REQ_FREQ_I || REQ_FREQ_I == 16'h0000)
    else $error("clamp exceeds request or ceiling");
  AST_NOMINAL_PASS: assert property (NOMINAL_FREQ_O == NOMINAL_FREQ_I)
    else $error("nominal frequency altered");
  AST_INJ_LEVEL_ZERO: assert property (!DC_INJECT_O |-> INJ_LEVEL_O == 8'h00)
    else $error("injection level outside injection");
  AST_BLANK_FIRST: assert property ($rose(DC_INJECT_O) |-> !$past(OUT_ENABLE_O) && OUT_FREQ_O == 16'h0000)
    else $error("injection began without blanking");
  AST_INJ_END_DONE: assert property ($fell(DC_INJECT_O) |-> STOP_DONE_O && !OUT_ENABLE_O)
    else $error("injection end did not complete the stop");
  AST_DONE_QUIET: assert property (STOP_DONE_O |-> !OUT_ENABLE_O && !DC_INJECT_O && OUT_FREQ_O == 16'h0000)
    else $error("output active while stop reported done");
  AST_PB_PRIORITY: assert property (POWER_BRAKE_ACTIVE_O |-> !STALL_ACTIVE_O && OUT_ENABLE_O && !DC_INJECT_O)
    else $error("power braking outside deceleration or beside stall hold");
  AST_DWELL_DRIVE: assert property (DWELL_ACTIVE_O |-> OUT_ENABLE_O && !DC_INJECT_O)
    else $error("dwell while not driving");
endmodule // stop_seq_checker
bind drive_stop_mode_sequencer stop_seq_checker u_stop_seq_checker (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .REQ_FREQ_I(REQ_FREQ_I), .CLAMPED_FREQ_O(CLAMPED_FREQ_O),
  .NOMINAL_FREQ_I(NOMINAL_FREQ_I), .NOMINAL_FREQ_O(NOMINAL_FREQ_O), .OUT_FREQ_O(OUT_FREQ_O),
  .OUT_ENABLE_O(OUT_ENABLE_O), .DC_INJECT_O(DC_INJECT_O), .INJ_LEVEL_O(INJ_LEVEL_O),
  .DWELL_ACTIVE_O(DWELL_ACTIVE_O), .STALL_ACTIVE_O(STALL_ACTIVE_O),
  .POWER_BRAKE_ACTIVE_O(POWER_BRAKE_ACTIVE_O), .STOP_DONE_O(STOP_DONE_O));

/* File: test/pwr_stage_model.sv */
// power stage and command source seen by the sequencer
`timescale 1ns/100ps
module pwr_stage_model (
  input  wire clk_i,
  input  wire run_req_i,
  input  wire regen_req_i,
  input  wire out_enable_i,
  output reg  run_cmd_o,
  output reg  overvolt_o
);
  // ----------------------------------------
  // command pin and bus voltage
  // ----------------------------------------
  initial begin
    run_cmd_o = 1'b0;
    overvolt_o = 1'b0;
  end
  // bus can only charge from regeneration while the stage is driving
  always @(posedge clk_i) begin
    run_cmd_o <= run_req_i;
    overvolt_o <= regen_req_i & out_enable_i;
  end
endmodule // pwr_stage_model

/* File: test/tb_top.sv */
// self-checking bench for the stop-mode sequencer
`timescale 1ns/100ps
module tb_top;
  logic        MCLK_I = 1'b0, NRST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0, DWELL_ENABLE_I = 1'b0;
  logic        run_req = 1'b0, regen_req = 1'b0, run_cmd, overvolt;
  logic [7:0]  ADDR_I = 8'h00;
  logic [15:0] WDATA_I = 16'h0000, REQ_FREQ_I = 16'h0100, f0;
  wire  [15:0] RDATA_O, OUT_FREQ_O, CLAMPED_FREQ_O;
  wire  [7:0]  INJ_LEVEL_O;
  wire         OUT_ENABLE_O, DC_INJECT_O, DWELL_ACTIVE_O, STALL_ACTIVE_O, POWER_BRAKE_ACTIVE_O, STOP_DONE_O;
  int          fail_count = 0, compares = 0, n;
  logic        inj_seen, dwell_seen;
  localparam int TPC = 4; // short tick keeps the run brief
  always #25 MCLK_I = ~MCLK_I;
  drive_stop_mode_sequencer #(.TICK_CYCLES(TPC)) u_drive_stop_mode_sequencer (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
    .CE_I(1'b1), .RUN_CMD_I(run_cmd), .BUS_OVERVOLT_I(overvolt), .DWELL_ENABLE_I(DWELL_ENABLE_I),
    .DWELL_FREQ_I(16'h0010), .REQ_FREQ_I(REQ_FREQ_I), .RAMP_STEP_I(16'h0010), .NOMINAL_FREQ_I(16'h2000),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OUT_FREQ_O(OUT_FREQ_O),
    .OUT_ENABLE_O(OUT_ENABLE_O), .DC_INJECT_O(DC_INJECT_O), .INJ_LEVEL_O(INJ_LEVEL_O),
    .DWELL_ACTIVE_O(DWELL_ACTIVE_O), .STALL_ACTIVE_O(STALL_ACTIVE_O), .POWER_BRAKE_ACTIVE_O(POWER_BRAKE_ACTIVE_O),
    .STOP_DONE_O(STOP_DONE_O), .CLAMPED_FREQ_O(CLAMPED_FREQ_O), .NOMINAL_FREQ_O());
  pwr_stage_model u_pwr_stage_model (.clk_i(MCLK_I), .run_req_i(run_req), .regen_req_i(regen_req),
    .out_enable_i(OUT_ENABLE_O), .run_cmd_o(run_cmd), .overvolt_o(overvolt));
  // sticky monitors, cleared by each stop test
  always @(posedge MCLK_I) begin
    if (DC_INJECT_O) inj_seen <= 1'b1;
    if (DWELL_ACTIVE_O) dwell_seen <= 1'b1;
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK_I) {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
    @(posedge MCLK_I) WR_I <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge MCLK_I) {RD_I, ADDR_I} <= {1'b1, a};
    @(posedge MCLK_I) RD_I <= 1'b0;
    @(negedge MCLK_I) chk("read data", RDATA_O, exp);
  endtask
  // ramp to the request in mode m, then drop the run command
  task run_stop(input logic [2:0] m);
    wr(8'h00, {13'h0000, m});
    @(negedge MCLK_I) {inj_seen, dwell_seen} = 2'b00;
    @(posedge MCLK_I) run_req <= 1'b1;
    for (n = 0; n < 100 && OUT_FREQ_O !== 16'h0100; n++) @(negedge MCLK_I);
    chk("ramped freq", OUT_FREQ_O, 16'h0100);
    @(posedge MCLK_I) run_req <= 1'b0;
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard: the tests need well under 3000 cycles
  initial begin
    #(50 * 5000);
    fail_count++;
    give_verdict;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    rc(8'h00, 16'h0000); rc(8'h01, 16'h000A); rc(8'h02, 16'h0064); rc(8'h03, 16'h0032);
    rc(8'h04, 16'h01F4); rc(8'h05, 16'h0032); rc(8'h06, 16'h1770); rc(8'h20, 16'h0000);
    $display("test defaults done");
    wr(8'h00, 16'h0005); wr(8'h03, 16'h00C9); wr(8'h06, 16'h0F9F); wr(8'h05, 16'h0000);
    rc(8'h00, 16'h0000); rc(8'h03, 16'h0032); rc(8'h06, 16'h1770); rc(8'h05, 16'h0032);
    wr(8'h03, 16'h00C8); wr(8'h07, 16'h0008);
    rc(8'h03, 16'h00C8); rc(8'h07, 16'h0008);
    $display("test refused writes done");
    @(posedge MCLK_I) REQ_FREQ_I <= 16'h0031;
    @(negedge MCLK_I) chk("below floor", CLAMPED_FREQ_O, 16'h0000);
    @(posedge MCLK_I) REQ_FREQ_I <= 16'h0032;
    @(negedge MCLK_I) chk("at floor", CLAMPED_FREQ_O, 16'h0032);
    @(posedge MCLK_I) REQ_FREQ_I <= 16'h2000;
    @(negedge MCLK_I) chk("above ceiling", CLAMPED_FREQ_O, 16'h1770);
    @(posedge MCLK_I) REQ_FREQ_I <= 16'h0100;
    $display("test clamp done");
    // deceleration, with a mode change in mid-stop that must not bite
    run_stop(3'h0);
    repeat (3) @(negedge MCLK_I);
    wr(8'h00, 16'h0002);
    @(negedge MCLK_I) chk("enable after mode change", OUT_ENABLE_O, 1'b1);
    // overvoltage in plain decel engages the stall hold
    @(posedge MCLK_I) regen_req <= 1'b1;
    for (n = 0; n < 8 && !STALL_ACTIVE_O; n++) @(negedge MCLK_I);
    chk("stall hold in decel", STALL_ACTIVE_O, 1'b1);
    @(posedge MCLK_I) regen_req <= 1'b0;
    for (n = 0; n < 100 && !STOP_DONE_O; n++) @(negedge MCLK_I);
    chk("decel long enough", n >= 8, 1'b1);
    chk("decel no inject", inj_seen, 1'b0);
    rc(8'h08, 16'h0006);
    $display("test decel stop done");
    // free run cuts the output within the sync delay
    run_stop(3'h2);
    for (n = 0; n < 20 && OUT_ENABLE_O; n++) @(negedge MCLK_I);
    chk("free run latency", n <= 5, 1'b1);
    @(negedge MCLK_I) chk("free run done", STOP_DONE_O, 1'b1);
    $display("test free run done");
    // power braking reaccelerates on overvoltage; stall hold yields to it
    run_stop(3'h4);
    repeat (4) @(negedge MCLK_I);
    f0 = OUT_FREQ_O;
    @(posedge MCLK_I) regen_req <= 1'b1;
    for (n = 0; n < 8 && !POWER_BRAKE_ACTIVE_O; n++) @(negedge MCLK_I);
    chk("power brake on", POWER_BRAKE_ACTIVE_O, 1'b1);
    repeat (3) @(negedge MCLK_I);
    chk("reaccelerated", OUT_FREQ_O > f0, 1'b1);
    chk("stall hold yields", STALL_ACTIVE_O, 1'b0);
    // dwell above nothing: held until the request drops
    @(posedge MCLK_I) {regen_req, DWELL_ENABLE_I} <= 2'b01;
    for (n = 0; n < 200 && !DWELL_ACTIVE_O; n++) @(negedge MCLK_I);
    chk("dwell held", DWELL_ACTIVE_O, 1'b1);
    @(posedge MCLK_I) DWELL_ENABLE_I <= 1'b0;
    for (n = 0; n < 200 && !STOP_DONE_O; n++) @(negedge MCLK_I);
    chk("power brake stop", STOP_DONE_O, 1'b1);
    $display("test power braking done");
    // dc braking: blank, inject at level, then done; low dwell is skipped
    @(posedge MCLK_I) DWELL_ENABLE_I <= 1'b1;
    run_stop(3'h1);
    for (n = 0; n < 60 && OUT_ENABLE_O; n++) @(negedge MCLK_I);
    chk("entry reached", OUT_ENABLE_O, 1'b0);
    for (n = 0; n < 80 && !DC_INJECT_O; n++) @(negedge MCLK_I);
    chk("blank span", n >= 10 * TPC - 4 && n <= 10 * TPC + 4, 1'b1);
    chk("inject level", INJ_LEVEL_O, 8'hC8);
    for (n = 0; n < 600 && DC_INJECT_O; n++) @(negedge MCLK_I);
    chk("hold span", n >= 100 * TPC - 4 && n <= 100 * TPC + 4, 1'b1);
    chk("brake done", STOP_DONE_O, 1'b1);
    chk("dwell skipped", dwell_seen, 1'b0);
    $display("test dc braking done");
    give_verdict;
  end
endmodule // tb_top
